// file: design/isp_pkg.sv
// shared constants and types for the serial programming port
package isp_pkg;

   // pin bundle positions seen by the input synchroniser
   localparam int PIN_MOSI = 0;
   localparam int PIN_SCK  = 1;
   localparam int PIN_RST  = 2;
   localparam int PIN_N    = 3;
   // reset pin high (normal run), serial clock and data low
   localparam logic [2:0] PIN_INIT = 3'h4;

   // memory geometry and busy counter width
   localparam int FLASH_ADDR_W = 13;   // word address
   localparam int PAGE_OFS_W   = 6;    // word within a page
   localparam int EE_ADDR_W    = 9;    // byte address
   localparam int BUSY_W       = 24;

   // instruction bytes and erased values
   localparam logic [7:0] OP_ENABLE     = 8'hAC;
   localparam logic [7:0] ENABLE_KEY    = 8'h53;
   localparam logic [7:0] ERASE_KEY     = 8'h80;
   localparam logic [7:0] OP_POLL       = 8'hF0;
   localparam logic [7:0] OP_LOAD_LO    = 8'h40;
   localparam logic [7:0] OP_LOAD_HI    = 8'h48;
   localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
   localparam logic [7:0] OP_READ_LO    = 8'h20;
   localparam logic [7:0] OP_READ_HI    = 8'h28;
   localparam logic [7:0] OP_EE_WRITE   = 8'hC0;
   localparam logic [7:0] OP_EE_READ    = 8'hA0;
   localparam logic [7:0] ERASED_BYTE   = 8'hFF;
   localparam logic [15:0] ERASED_WORD  = 16'hFFFF;

   // self-timed programming times, each within its minimum wait delay
   localparam int CLK_PERIOD_NS            = 10;
   localparam int FLASH_PAGE_WAIT_DELAY_NS = 4_500_000;
   localparam int EEPROM_BYTE_WAIT_DELAY_NS = 9_000_000;
   localparam int CHIP_ERASE_WAIT_DELAY_NS = 9_000_000;
   localparam int FLASH_PAGE_WAIT_CYC  =
      FLASH_PAGE_WAIT_DELAY_NS / CLK_PERIOD_NS;
   localparam int EEPROM_BYTE_WAIT_CYC =
      EEPROM_BYTE_WAIT_DELAY_NS / CLK_PERIOD_NS;
   localparam int CHIP_ERASE_WAIT_CYC  =
      CHIP_ERASE_WAIT_DELAY_NS / CLK_PERIOD_NS;

   // one four-byte instruction, first byte in the top bits
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
   } isp_instr_t;

   // self-timed operation in progress
   typedef enum {ISP_OP_NONE, ISP_OP_FLASH, ISP_OP_EEPROM, ISP_OP_ERASE}
      isp_op_t;

endpackage

// file: design/isp_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module isp_pin_sync #(
   parameter int               WIDTH = 3,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   input  wire logic             clock,  // system clock
   input  wire logic             rst,    // synchronous reset, high
   input  wire logic [WIDTH-1:0] din,    // asynchronous pins
   output logic      [WIDTH-1:0] level,  // filtered level
   output logic      [WIDTH-1:0] rise,   // one-cycle rising pulse
   output logic      [WIDTH-1:0] fall    // one-cycle falling pulse
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // stage one feeds stage two only, to keep metastability contained
   always_ff @(posedge clock) begin
      if (rst) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a change counts only once stages two and three agree
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
         if (rst) begin
            level[i] <= INIT[i];
            rise[i]  <= 1'b0;
            fall[i]  <= 1'b0;
         end else begin
            rise[i] <= (s2_r[i] == s3_r[i]) && s3_r[i] && !level[i];
            fall[i] <= (s2_r[i] == s3_r[i]) && !s3_r[i] && level[i];
            if (s2_r[i] == s3_r[i]) begin
               level[i] <= s3_r[i];
            end
         end
      end
   end

endmodule // isp_pin_sync

// file: design/isp_serial_prog.sv
// serial in-system programming port with flash and eeprom arrays
`timescale 1ns/1ps
// Contract
// [R1] programming only while reset pin held low
// [R2] enable instruction first, else operations rejected
// [R3] eeprom write erases its byte itself
// [R4] chip erase fills flash and eeprom with ones
// [R5] programmer keeps clock phases over cycles
// [R6] data in sampled on clock rising edge
// [R7] data out shifted on clock falling edge
// [R8] programmer powers up with reset, clock low
// [R9] programmer waits 20 ms before enabling; the model settles for 200 clocks
// [R10] second enable byte echoed during third
// [R11] programmer sends four bytes, retries on mismatch
// [R12] page buffer loaded bytewise by six bits
// [R13] programmer loads low byte before high
// [R14] write page commits buffer at seven bits
// [R15] programmer waits flash page delay
// [R16] eeprom written one byte per instruction
// [R17] read returns stored content on data out
// [R18] reset pin high ends programming, runs cpu
// [R19] page being programmed reads all ones
// [R20] programmer uses fixed wait for ones; the bench polls the busy bit instead
// [R21] eeprom byte being programmed reads ones
// [R22] programmer waits after erase and fuses
// [R23] poll returns busy in lowest bit
// [R24] four-byte instructions, enable is AC 53
// [R25] msb first, framing restarts on reset
module isp_serial_prog #(
   parameter int FLASH_ADDR_W   = isp_pkg::FLASH_ADDR_W,
   parameter int EE_ADDR_W      = isp_pkg::EE_ADDR_W,
   parameter int FLASH_WAIT_CYC = isp_pkg::FLASH_PAGE_WAIT_CYC,
   parameter int EE_WAIT_CYC    = isp_pkg::EEPROM_BYTE_WAIT_CYC,
   parameter int ERASE_WAIT_CYC = isp_pkg::CHIP_ERASE_WAIT_CYC
) (
   input  wire logic clock,           // system clock, 100 MHz
   input  wire logic rst,             // synchronous reset, high
   input  wire logic reset_pin_n,     // device reset pin, low = program
   input  wire logic sck,             // serial clock from programmer
   input  wire logic mosi,            // serial data in
   output logic      miso,            // serial data out
   output logic      prog_mode,       // programming enabled
   output logic      ready_busy_flag, // self-timed operation pending
   output logic      cpu_run          // device released to normal run
);

   localparam int PW      = isp_pkg::PAGE_OFS_W;
   localparam int PAGE_N  = 1 << PW;
   localparam int FLASH_N = 1 << FLASH_ADDR_W;
   localparam int EE_N    = 1 << EE_ADDR_W;
   localparam int BW      = isp_pkg::BUSY_W;
   localparam int SW      = FLASH_ADDR_W + 1;

   logic [isp_pkg::PIN_N-1:0] pin_lvl;
   logic [isp_pkg::PIN_N-1:0] pin_rise;
   logic [isp_pkg::PIN_N-1:0] pin_fall;

   logic                    session;
   logic                    sck_rise;
   logic                    sck_fall;
   logic [4:0]              bit_cnt_r;
   logic [31:0]             rx_sr_r;
   logic [31:0]             rx_next;
   logic                    instr_done;
   logic                    byte_done;
   isp_pkg::isp_instr_t     instr;
   logic [7:0]              tx_sr_r;
   logic [7:0]              tx_load;
   logic [7:0]              rd_byte;
   logic                    miso_r;
   logic                    prog_en_r;
   logic                    busy_r;
   logic                    cpu_run_r;
   logic [BW-1:0]           busy_cnt_r;
   isp_pkg::isp_op_t        busy_op_r;
   logic [FLASH_ADDR_W-1:0] busy_faddr_r;
   logic [EE_ADDR_W-1:0]    busy_eaddr_r;
   logic [SW-1:0]           sweep_r;
   logic                    accept;
   logic [FLASH_ADDR_W-1:0] rd_faddr;
   logic [EE_ADDR_W-1:0]    rd_eaddr;
   logic [15:0]             rd_word;
   logic [FLASH_ADDR_W-1:0] wr_faddr;

   logic [15:0] flash_mem [FLASH_N];
   logic [7:0]  ee_mem    [EE_N];
   logic [15:0] page_buf  [PAGE_N];

   // word and byte address carried in bytes two and three
   function automatic logic [FLASH_ADDR_W-1:0] f_addr(input logic [15:0] a);
      f_addr = a[FLASH_ADDR_W-1:0];
   endfunction

   function automatic logic [EE_ADDR_W-1:0] e_addr(input logic [15:0] a);
      e_addr = a[EE_ADDR_W-1:0];
   endfunction

   // reset, clock and data pins all pass the three-stage filter
   isp_pin_sync #(
      .WIDTH (isp_pkg::PIN_N),
      .INIT  (isp_pkg::PIN_INIT)
   ) u_pin_sync (
      .clock (clock),
      .rst   (rst),
      .din   ({reset_pin_n, sck, mosi}),
      .level (pin_lvl),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   // the serial port only listens while the reset pin is low
   assign session  = !pin_lvl[isp_pkg::PIN_RST];                  // [R1]
   assign sck_rise = session && pin_rise[isp_pkg::PIN_SCK];
   assign sck_fall = session && pin_fall[isp_pkg::PIN_SCK];
   assign rx_next  = {rx_sr_r[30:0], pin_lvl[isp_pkg::PIN_MOSI]};
   assign instr    = isp_pkg::isp_instr_t'(rx_next);
   assign instr_done = sck_rise && (bit_cnt_r == 5'h1F);          // [R24]
   assign byte_done  = sck_rise && (bit_cnt_r[2:0] == 3'h7);

   // receive shifter, msb first; a reset pulse restarts framing
   always_ff @(posedge clock) begin
      if (rst || !session) begin
         bit_cnt_r <= 5'h00;                                      // [R25]
         rx_sr_r   <= 32'h0000_0000;
      end else if (sck_rise) begin
         rx_sr_r   <= rx_next;                                    // [R6]
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   // read side lookup for the fourth byte, ones from the page or byte being programmed and during erase
   assign rd_faddr = f_addr(rx_next[15:0]);
   assign rd_eaddr = e_addr(rx_next[15:0]);
   assign rd_word  = flash_mem[rd_faddr];

   // word address of a page write; its top bits pick the page
   assign wr_faddr = f_addr({instr.b2, instr.b3});

   always_comb begin
      rd_byte = 8'h00;
      if (prog_en_r) begin
         unique case (rx_next[23:16])
            isp_pkg::OP_POLL:    rd_byte = {7'h00, busy_r};        // [R23]
            isp_pkg::OP_READ_LO: rd_byte = rd_word[7:0];           // [R17]
            isp_pkg::OP_READ_HI: rd_byte = rd_word[15:8];          // [R17]
            isp_pkg::OP_EE_READ: rd_byte = ee_mem[rd_eaddr];       // [R17]
            default:             rd_byte = 8'h00;
         endcase
         if ((rx_next[23:16] == isp_pkg::OP_READ_LO ||
              rx_next[23:16] == isp_pkg::OP_READ_HI) &&
             busy_op_r == isp_pkg::ISP_OP_FLASH &&
             rd_faddr[FLASH_ADDR_W-1:PW] ==
             busy_faddr_r[FLASH_ADDR_W-1:PW]) begin
            rd_byte = isp_pkg::ERASED_BYTE;                        // [R19]
         end
         if (rx_next[23:16] == isp_pkg::OP_EE_READ &&
             busy_op_r == isp_pkg::ISP_OP_EEPROM &&
             rd_eaddr == busy_eaddr_r) begin
            rd_byte = isp_pkg::ERASED_BYTE;                        // [R21]
         end
         if (busy_op_r == isp_pkg::ISP_OP_ERASE &&
             rx_next[23:16] != isp_pkg::OP_POLL) begin
            rd_byte = isp_pkg::ERASED_BYTE;
         end
      end
   end

   // next outgoing byte: echo of byte one or two, data in slot four, zero after byte four
   always_comb begin
      unique case (bit_cnt_r[4:3])
         2'h2:    tx_load = rd_byte;
         2'h3:    tx_load = 8'h00;
         default: tx_load = rx_next[7:0];                          // [R10]
      endcase
   end

   // transmit shifter, a bit leaves on each falling clock edge
   always_ff @(posedge clock) begin
      if (rst || !session) begin
         tx_sr_r <= 8'h00;
         miso_r  <= 1'b0;
      end else begin
         if (byte_done) begin
            tx_sr_r <= tx_load;
         end else if (sck_fall) begin
            tx_sr_r <= {tx_sr_r[6:0], 1'b0};
         end
         if (sck_fall) begin
            miso_r <= tx_sr_r[7];                                  // [R7]
         end
      end
   end

   // writes and erase are refused until enabled and while busy
   assign accept = instr_done && prog_en_r &&
                   busy_op_r == isp_pkg::ISP_OP_NONE;              // [R2]

   // enable state; leaving the reset-low session drops it
   always_ff @(posedge clock) begin
      if (rst) begin
         prog_en_r <= 1'b0;
         cpu_run_r <= 1'b1;
      end else begin
         cpu_run_r <= pin_lvl[isp_pkg::PIN_RST];                   // [R18]
         if (!session) begin
            prog_en_r <= 1'b0;                                     // [R18]
         end else if (instr_done && instr.op == isp_pkg::OP_ENABLE &&
                      instr.b2 == isp_pkg::ENABLE_KEY) begin
            prog_en_r <= 1'b1;                                     // [R2]
         end
      end
   end

   // self-timed operation tracker; keeps running across a reset pulse
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_cnt_r   <= '0;
         busy_op_r    <= isp_pkg::ISP_OP_NONE;
         busy_r       <= 1'b0;
         busy_faddr_r <= '0;
         busy_eaddr_r <= '0;
      end else if (accept && instr.op == isp_pkg::OP_ENABLE &&
                   instr.b2 == isp_pkg::ERASE_KEY) begin
         busy_cnt_r <= BW'(ERASE_WAIT_CYC);
         busy_op_r  <= isp_pkg::ISP_OP_ERASE;
         busy_r     <= 1'b1;
      end else if (accept && instr.op == isp_pkg::OP_WRITE_PAGE) begin
         busy_cnt_r   <= BW'(FLASH_WAIT_CYC);
         busy_op_r    <= isp_pkg::ISP_OP_FLASH;
         busy_r       <= 1'b1;
         busy_faddr_r <= f_addr({instr.b2, instr.b3});
      end else if (accept && instr.op == isp_pkg::OP_EE_WRITE) begin
         busy_cnt_r   <= BW'(EE_WAIT_CYC);
         busy_op_r    <= isp_pkg::ISP_OP_EEPROM;
         busy_r       <= 1'b1;
         busy_eaddr_r <= e_addr({instr.b2, instr.b3});
      end else if (busy_cnt_r > BW'(1)) begin
         busy_cnt_r <= busy_cnt_r - BW'(1);
      end else begin
         busy_cnt_r <= '0;
         busy_op_r  <= isp_pkg::ISP_OP_NONE;
         busy_r     <= 1'b0;
      end
   end

   // erase sweep index; the top bit marks the sweep finished
   always_ff @(posedge clock) begin
      if (rst) begin
         sweep_r <= {1'b1, {FLASH_ADDR_W{1'b0}}};
      end else if (accept && instr.op == isp_pkg::OP_ENABLE &&
                   instr.b2 == isp_pkg::ERASE_KEY) begin
         sweep_r <= '0;
      end else if (!sweep_r[SW-1]) begin
         sweep_r <= sweep_r + SW'(1);
      end
   end

   // page buffer, one byte per load instruction at the low six bits
   always_ff @(posedge clock) begin
      if (accept && instr.op == isp_pkg::OP_LOAD_LO) begin
         page_buf[instr.b3[PW-1:0]][7:0] <= instr.b4;               // [R12]
      end else if (accept && instr.op == isp_pkg::OP_LOAD_HI) begin
         page_buf[instr.b3[PW-1:0]][15:8] <= instr.b4;              // [R12]
      end
   end

   // arrays: whole-page commit, eeprom byte write, erase one word a cycle
   always_ff @(posedge clock) begin
      if (accept && instr.op == isp_pkg::OP_WRITE_PAGE) begin
         for (int i = 0; i < PAGE_N; i++) begin
            flash_mem[{wr_faddr[FLASH_ADDR_W-1:PW], PW'(i)}] <=
               page_buf[i];                                        // [R14]
         end
      end
      if (accept && instr.op == isp_pkg::OP_EE_WRITE) begin
         // plain overwrite stands in for the built-in erase-then-write
         ee_mem[e_addr({instr.b2, instr.b3})] <= instr.b4;          // [R3] [R16]
      end
      if (!sweep_r[SW-1]) begin
         flash_mem[sweep_r[FLASH_ADDR_W-1:0]] <= isp_pkg::ERASED_WORD; // [R4]
         if (sweep_r < SW'(EE_N)) begin
            ee_mem[sweep_r[EE_ADDR_W-1:0]] <= isp_pkg::ERASED_BYTE;   // [R4]
         end
      end
   end

   assign miso            = miso_r;
   assign prog_mode       = prog_en_r;
   assign ready_busy_flag = busy_r;
   assign cpu_run         = cpu_run_r;

endmodule // isp_serial_prog

// file: verification/isp_serial_prog_properties.sv
// pin-level checks for the serial programming port
`timescale 1ns/1ps
module isp_serial_prog_properties #(
   parameter int FLASH_WAIT_CYC = 2000,
   parameter int EE_WAIT_CYC    = 3000,
   parameter int ERASE_WAIT_CYC = 8200
) (
   input wire logic clock,           // system clock
   input wire logic rst,             // synchronous reset
   input wire logic reset_pin_n,     // device reset pin
   input wire logic sck,             // serial clock
   input wire logic mosi,            // serial data in
   input wire logic miso,            // serial data out
   input wire logic prog_mode,       // programming enabled
   input wire logic ready_busy_flag, // self-timed work pending
   input wire logic cpu_run          // normal run
);
   int busy_cnt_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // length of the running busy stretch, judged when it ends
   always_ff @(posedge clock) begin
      if (rst || !ready_busy_flag) busy_cnt_r <= 0;
      else busy_cnt_r <= busy_cnt_r + 1;
   end

   a_busy_length: assert property ($fell(ready_busy_flag) |->
      busy_cnt_r == FLASH_WAIT_CYC || busy_cnt_r == EE_WAIT_CYC ||
      busy_cnt_r == ERASE_WAIT_CYC) else $error("busy stretch length off");
   a_busy_in_mode: assert property ($rose(ready_busy_flag) |->
      prog_mode) else $error("write started outside programming mode");
   a_mode_entry: assert property ($rose(prog_mode) |->
      !cpu_run && !$past(reset_pin_n, 8)) else $error("mode entry bad");
   a_mode_hold: assert property ((!reset_pin_n)[*8] ##0 prog_mode
      |=> prog_mode) else $error("mode lost with reset pin low");
   a_pin_drops_mode: assert property (reset_pin_n[*8] |->
      !prog_mode) else $error("mode kept with reset pin high");
   a_cpu_release: assert property ($rose(reset_pin_n) |->
      ##[1:8] cpu_run) else $error("cpu not released");
   a_cpu_hold: assert property ($fell(reset_pin_n) |->
      ##[1:8] !cpu_run) else $error("cpu not held");
   // the pin filter delays every clock edge, so data out moves five
   // clocks after the clock pin falls, often inside the next high phase
   a_miso_on_fall: assert property ($changed(miso) &&
      !$past(reset_pin_n, 5) |-> $past(sck, 6) && !$past(sck, 5))
      else $error("data out moved away from a clock fall");
endmodule // isp_serial_prog_properties

// the parameter defaults above follow the wait counts the bench gives
bind isp_serial_prog isp_serial_prog_properties
   isp_serial_prog_properties_inst (.clock(clock), .rst(rst),
   .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso),
   .prog_mode(prog_mode), .ready_busy_flag(ready_busy_flag),
   .cpu_run(cpu_run));

// file: verification/isp_prog_model.sv
// serial programmer model driving reset, clock and data pins
`timescale 1ns/1ps
module isp_prog_model #(
   parameter int PWR_WAIT_CYC = 200
) (
   input  wire logic clock,       // system clock, pins move on its fall
   input  wire logic miso,        // data from the device
   output logic      reset_pin_n, // device reset pin
   output logic      sck,         // serial clock
   output logic      mosi         // serial data out
);
   // power up with reset and clock low so no stray edge is seen
   initial begin
      reset_pin_n = 1'b0;
      sck         = 1'b0;
      mosi        = 1'b0;
   end

   // settling time before the first instruction, scaled down
   task automatic settle();
      repeat (PWR_WAIT_CYC) @(negedge clock);
   endtask

   task automatic set_pin(input logic v);
      @(negedge clock);
      reset_pin_n = v;
   endtask

   // one bit, entered on a falling clock edge; each phase lasts half
   // clocks, data in on the rise, data out taken late in the high phase
   task automatic bit_cycle(input logic b, input int half, output logic r);
      mosi = b;
      repeat (half) @(negedge clock);
      sck = 1'b1;
      repeat (half - 1) @(negedge clock);
      r = miso;
      @(negedge clock);
      sck = 1'b0; // clock idles low between frames
   endtask

   // always all four bytes, msb first
   task automatic xfer(input logic [31:0] w, input int half,
                       output logic [31:0] got);
      for (int i = 31; i >= 0; i--) bit_cycle(w[i], half, got[i]);
   endtask

   // a few loose bits to throw the device framing off
   task automatic stray(input logic [2:0] b);
      logic r;
      for (int i = 2; i >= 0; i--) bit_cycle(b[i], 4, r);
   endtask
endmodule // isp_prog_model

// file: verification/tb.sv
// self-checking bench for the serial programming port
`timescale 1ns/1ps
module tb;
   logic        clock;
   logic        rst;
   logic        reset_pin_n;
   logic        sck;
   logic        mosi;
   logic        miso;
   logic        prog_mode;
   logic        ready_busy_flag;
   logic        cpu_run;
   logic [31:0] rs = 32'h0000E244;
   logic [31:0] got;
   logic [31:0] a;
   logic [31:0] d;
   logic [7:0]  mem_m[int]; // flash bytes at 2*word+hi, eeprom at 'h10000+
   int          wl[4];
   int          ofs[4] = '{0, 1, 62, 63};
   int          err_total = 0;
   int          num_checks = 0;

   isp_serial_prog #(.FLASH_WAIT_CYC(2000), .EE_WAIT_CYC(3000),
      .ERASE_WAIT_CYC(8200)) isp_serial_prog_inst (.clock(clock),
      .rst(rst), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi),
      .miso(miso), .prog_mode(prog_mode),
      .ready_busy_flag(ready_busy_flag), .cpu_run(cpu_run));
   isp_prog_model isp_prog_model_inst (.clock(clock), .miso(miso),
      .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   // never written since erase reads as all ones
   function automatic logic [7:0] expv(input int k);
      return mem_m.exists(k) ? mem_m[k] : 8'hFF;
   endfunction

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_flag(input logic g, input logic e);
      chk_byte({7'h00, g}, {7'h00, e});
   endtask

   task automatic cmd(input logic [31:0] w);
      isp_prog_model_inst.xfer(w, 4, got);
   endtask

   task automatic rd(input logic [7:0] op, input int ad, input logic [7:0] e);
      cmd({op, ad[15:0], 8'h00});
      chk_byte(got[7:0], e);
   endtask

   // polling replaces the fixed wait; bounded so a stuck flag fails
   task automatic poll_wait();
      for (int i = 0; i < 60; i++) begin
         cmd(32'hF000_0000);
         chk_byte({got[7:1], 1'b0}, 8'h00);
         if (got[0] === 1'b0) return;
      end
      chk_flag(1'b1, 1'b0);
   endtask

   // retry with a reset pulse when the echo is wrong
   task automatic enable(input int half);
      for (int t = 0; t < 2; t++) begin
         isp_prog_model_inst.xfer(32'hAC53_0000, half, got);
         chk_byte(got[15:8], 8'h53);
         if (got[15:8] === 8'h53) break;
         isp_prog_model_inst.set_pin(1'b1);
         repeat (8) @(negedge clock);
         isp_prog_model_inst.set_pin(1'b0);
         repeat (8) @(negedge clock);
      end
      repeat (8) @(negedge clock);
      chk_flag(prog_mode, 1'b1);
   endtask

   task automatic ee_wr(input int ad, input logic [7:0] v);
      cmd({8'hC0, ad[15:0], v});
      mem_m[32'h10000 + ad] = v;
      rd(8'hA0, ad, 8'hFF);
      poll_wait();
      rd(8'hA0, ad, v);
   endtask

   task automatic refused();
      cmd(32'hC005_0012);
      repeat (8) @(negedge clock);
      chk_flag(ready_busy_flag, 1'b0);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clock);
      err_total++;
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      isp_prog_model_inst.settle();
      chk_flag(cpu_run, 1'b0);
      refused();
      enable(4);
      $display("test enable done");
      // erase: busy, reads give ones during and after
      cmd(32'hAC80_0000);
      mem_m.delete();
      repeat (8) @(negedge clock);
      chk_flag(ready_busy_flag, 1'b1);
      rd(8'h20, 0, 8'hFF);
      poll_wait();
      for (int i = 0; i < 4; i++) begin
         a = xs();
         rd(8'h28, a[12:0], 8'hFF);
         rd(8'hA0, a[24:16], 8'hFF);
      end
      $display("test erase done");
      // page at both ends of the word offset range
      a = xs();
      for (int i = 0; i < 4; i++) begin
         wl[i] = a[12:6] * 64 + ofs[i];
         d = xs();
         cmd({8'h40, 3'h0, wl[i][12:0], d[7:0]});
         cmd({8'h48, 3'h0, wl[i][12:0], d[15:8]});
         mem_m[2 * wl[i]] = d[7:0];
         mem_m[2 * wl[i] + 1] = d[15:8];
      end
      cmd({8'h4C, 3'h0, a[12:6], 6'h00, 8'h00});
      rd(8'h20, wl[3], 8'hFF);
      poll_wait();
      foreach (wl[i]) begin
         rd(8'h20, wl[i], expv(2 * wl[i]));
         rd(8'h28, wl[i], expv(2 * wl[i] + 1));
      end
      $display("test page done");
      // rewrite with inverted bits needs the built-in erase
      a = xs() & 32'h1FF;
      d = xs();
      ee_wr(a, d[7:0]);
      ee_wr(a, ~d[7:0]);
      $display("test eeprom done");
      // misframe, leave and re-enter through the reset pin
      isp_prog_model_inst.stray(3'h5);
      isp_prog_model_inst.set_pin(1'b1);
      repeat (12) @(negedge clock);
      chk_flag(cpu_run, 1'b1);
      chk_flag(prog_mode, 1'b0);
      isp_prog_model_inst.set_pin(1'b0);
      repeat (12) @(negedge clock);
      refused();
      enable(4);
      rd(8'hA0, a, expv(32'h10000 + a));
      // byte 5 must still read as erased; the refused write before enabling aimed at this very byte
      rd(8'hA0, 5, expv(32'h10005));
      $display("test reset done");
      report_and_stop();
   end
endmodule // tb
